//--- design/pcq_params.svh
`ifndef PCQ_PARAMS_SVH
`define PCQ_PARAMS_SVH

// counter geometry and restart values
`define PCQ_CNT_W 16
`define PCQ_CNT_FIRST 16'h0000
`define PCQ_CNT_RESTART 16'h0001

// prescaler: divide by 2**pre, pre from 0 to 10
`define PCQ_PRE_W 4
`define PCQ_DIV_W 11
`define PCQ_PRE_MAX 4'hA

// reset values
`define PCQ_PER_RST 16'hFFFF
`define PCQ_DUTY_RST 16'h0000

`endif

//--- design/pcq_pkg.sv
package pcq_pkg;

    // channel run state
    typedef enum logic [1:0] {
        PCQ_IDLE = 2'b00,
        PCQ_RUN = 2'b01,
        PCQ_DRAIN = 2'b10
    } pcq_state_t;

    // static channel configuration
    typedef struct packed {
        logic center_align_select;
        logic polarity;
        logic [3:0] prescale;
    } pcq_cfg_t;

    // pending period update
    typedef struct packed {
        logic valid;
        logic [15:0] value;
    } pcq_upd_t;

endpackage : pcq_pkg

//--- design/pcq_tick_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "pcq_params.svh"

module pcq_tick_gen (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic run,
    input wire logic [`PCQ_PRE_W-1:0] prescale,
    output logic tick
);

    logic [`PCQ_DIV_W-1:0] div_r;
    logic [`PCQ_DIV_W-1:0] div_nxt;

    // terminal count of the divider, clamped to the largest ratio
    function automatic logic [`PCQ_DIV_W-1:0] pcq_mask(
        input logic [`PCQ_PRE_W-1:0] pre);
        logic [`PCQ_PRE_W-1:0] p;
        p = (pre > `PCQ_PRE_MAX) ? `PCQ_PRE_MAX : pre;
        pcq_mask = `PCQ_DIV_W'((12'h001 << p) - 12'h001);
    endfunction : pcq_mask

    // tick once per 2**prescale clocks; held at zero while stopped
    assign tick = run && (div_r == pcq_mask(prescale));

    always_comb begin
        if (!run || tick) begin
            div_nxt = '0;
        end else begin
            div_nxt = div_r + `PCQ_DIV_W'(1);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end

endmodule : pcq_tick_gen

`default_nettype wire

//--- design/pcq_channel.sv
`timescale 1ns/100ps
`default_nettype none
`include "pcq_params.svh"

// Function
// - first period from zero, later from one
// - center-aligned enable raises event at once
// - zero update value is ignored
// - enabled bit stays one until period ends
module pcq_channel #(
    parameter int CW = `PCQ_CNT_W
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire pcq_pkg::pcq_cfg_t cfg,
    input wire logic chan_enable,
    input wire logic period_wr,
    input wire logic [CW-1:0] period_data,
    input wire logic duty_wr,
    input wire logic [CW-1:0] duty_data,
    input wire logic upd_wr,
    input wire logic [CW-1:0] channel_update_register,
    output logic pwm_out,
    output logic channel_enabled_bit,
    output logic chan_event,
    output logic [CW-1:0] cnt_value
);

    pcq_pkg::pcq_state_t state_r;
    pcq_pkg::pcq_state_t state_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic [CW-1:0] per_r;
    logic [CW-1:0] per_nxt;
    logic [CW-1:0] duty_r;
    logic [CW-1:0] duty_nxt;
    logic pend_v_r;
    logic pend_v_nxt;
    logic [CW-1:0] pend_r;
    logic [CW-1:0] pend_nxt;
    logic event_r;
    logic event_nxt;
    logic pwm_r;
    logic pwm_nxt;
    logic tick;
    logic start;
    logic wrap;

    // channel clock from the prescaler, runs only while the channel runs
    pcq_tick_gen u_tick (
        .mclk(mclk),
        .rstn(rstn),
        .run(state_r != pcq_pkg::PCQ_IDLE),
        .prescale(cfg.prescale),
        .tick(tick)
    );

    assign start = chan_enable && (state_r == pcq_pkg::PCQ_IDLE);
    assign wrap = tick && (cnt_r >= per_r);

    // run state and period counter
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            pcq_pkg::PCQ_IDLE: begin
                if (chan_enable) begin
                    state_nxt = pcq_pkg::PCQ_RUN;
                    cnt_nxt = CW'(`PCQ_CNT_FIRST);
                end
            end
            pcq_pkg::PCQ_RUN, pcq_pkg::PCQ_DRAIN: begin
                if (!chan_enable) begin
                    state_nxt = pcq_pkg::PCQ_DRAIN;
                end else begin
                    state_nxt = pcq_pkg::PCQ_RUN;
                end
                if (wrap) begin
                    cnt_nxt = CW'(`PCQ_CNT_RESTART);
                    if (!chan_enable) begin
                        state_nxt = pcq_pkg::PCQ_IDLE;
                        cnt_nxt = CW'(`PCQ_CNT_FIRST);
                    end
                end else if (tick) begin
                    cnt_nxt = cnt_r + CW'(1);
                end
            end
            default: begin
                state_nxt = pcq_pkg::PCQ_IDLE;
                cnt_nxt = CW'(`PCQ_CNT_FIRST);
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_r <= pcq_pkg::PCQ_IDLE;
            cnt_r <= CW'(`PCQ_CNT_FIRST);
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // period, duty and the update path applied at period end
    always_comb begin
        per_nxt = per_r;
        duty_nxt = duty_r;
        pend_v_nxt = pend_v_r;
        pend_nxt = pend_r;
        if (period_wr && (state_r == pcq_pkg::PCQ_IDLE)) begin
            per_nxt = period_data;
        end
        if (duty_wr) begin
            duty_nxt = duty_data;
        end
        if (wrap && pend_v_r) begin
            per_nxt = pend_r;
            pend_v_nxt = 1'b0;
        end
        // a zero value never reaches the pending slot
        if (upd_wr && (channel_update_register != '0)) begin
            pend_v_nxt = 1'b1;
            pend_nxt = channel_update_register;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            per_r <= CW'(`PCQ_PER_RST);
            duty_r <= CW'(`PCQ_DUTY_RST);
            pend_v_r <= 1'b0;
            pend_r <= '0;
        end else begin
            per_r <= per_nxt;
            duty_r <= duty_nxt;
            pend_v_r <= pend_v_nxt;
            pend_r <= pend_nxt;
        end
    end

    // channel event and waveform
    always_comb begin
        event_nxt = wrap && (state_r == pcq_pkg::PCQ_RUN);
        if (start && cfg.center_align_select) begin
            event_nxt = 1'b1;
        end
        pwm_nxt = cfg.polarity;
        if (state_r == pcq_pkg::PCQ_RUN) begin
            pwm_nxt = (cnt_r < duty_r) ^ cfg.polarity;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            event_r <= 1'b0;
            pwm_r <= 1'b0;
        end else begin
            event_r <= event_nxt;
            pwm_r <= pwm_nxt;
        end
    end

    // outputs
    assign chan_event = event_r;
    assign pwm_out = pwm_r;
    assign cnt_value = cnt_r;
    assign channel_enabled_bit = (state_r != pcq_pkg::PCQ_IDLE);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    first_count_zero_a: assert property (
        start |=> (cnt_r == '0) && (state_r == pcq_pkg::PCQ_RUN))
        else $error("first period did not start at zero");

    restart_at_one_a: assert property (
        (state_r == pcq_pkg::PCQ_RUN) && wrap && chan_enable
        |=> cnt_r == CW'(1))
        else $error("counter did not restart at one");

    center_event_a: assert property (
        start && cfg.center_align_select |=> chan_event)
        else $error("no event on center-aligned enable");

    zero_update_a: assert property (
        upd_wr && (channel_update_register == '0) && !wrap
        |=> (pend_v_r == $past(pend_v_r)) && (pend_r == $past(pend_r)))
        else $error("zero update value was taken");

    drain_status_a: assert property (
        $fell(chan_enable) && (state_r == pcq_pkg::PCQ_RUN) && !wrap
        |=> channel_enabled_bit && (state_r == pcq_pkg::PCQ_DRAIN))
        else $error("enabled bit dropped before period end");

    drain_end_a: assert property (
        (state_r == pcq_pkg::PCQ_DRAIN) && wrap && !chan_enable
        |=> !channel_enabled_bit)
        else $error("enabled bit stuck after period end");

    count_step_a: assert property (
        (state_r != pcq_pkg::PCQ_IDLE) && tick && !wrap
        |=> cnt_r == $past(cnt_r) + CW'(1))
        else $error("counter did not step by one");

    left_no_event_a: assert property (
        start && !cfg.center_align_select |=> !chan_event)
        else $error("event on left-aligned enable");

    period_event_a: assert property (
        (state_r == pcq_pkg::PCQ_RUN) && wrap |=> chan_event)
        else $error("no event at period end");

    update_load_a: assert property (
        wrap && pend_v_r |=> (per_r == $past(pend_r)) && (per_r != '0))
        else $error("pending period not loaded at wrap");

endmodule : pcq_channel

`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic mclk, rstn, chan_enable, period_wr, duty_wr, upd_wr;
    logic pwm_out, channel_enabled_bit, chan_event;
    logic [15:0] period_data, duty_data, upd_data, cnt_value;
    pcq_pkg::pcq_cfg_t cfg;
    int cyc, err_total, check_count, n, nw, p, p2, pre;
    int q[$];

    pcq_channel u_pcq_channel (.mclk(mclk), .rstn(rstn), .cfg(cfg),
        .chan_enable(chan_enable), .period_wr(period_wr),
        .period_data(period_data), .duty_wr(duty_wr), .duty_data(duty_data),
        .upd_wr(upd_wr), .channel_update_register(upd_data),
        .pwm_out(pwm_out), .channel_enabled_bit(channel_enabled_bit),
        .chan_event(chan_event), .cnt_value(cnt_value));

    // clock and cycle stamp
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (e !== g) begin
            err_total++;
            $display("BAD %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk

    task report_and_stop;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    // inputs change just after the rising edge
    task tick(input int k);
        repeat (k) begin
            @(posedge mclk);
            #1;
        end
    endtask : tick

    task tick_to(input int c);
        for (int i = 0; i < 400 && cyc < c; i++) tick(1);
        if (cyc < c) begin
            chk("wait_bound", 0, 1);
            report_and_stop();
        end
    endtask : tick_to

    // monitor: each event takes the oldest expected stamp
    always @(negedge mclk) begin
        if (chan_event === 1'b1) begin
            if (q.size() == 0) chk("extra_event", 0, 1);
            else chk("event_cycle", q.pop_front(), cyc);
        end
    end

    // hang guard
    initial begin
        #2000000;
        chk("timeout", 0, 1);
        report_and_stop();
    end

    // main sequence
    initial begin
        rstn = 1'b0;
        chan_enable = 1'b0;
        period_wr = 1'b0;
        duty_wr = 1'b0;
        upd_wr = 1'b0;
        cfg = '0;
        period_data = 16'h0000;
        duty_data = 16'h0000;
        upd_data = 16'h0000;
        void'($urandom(32'hCAFAD6A0));
        p = 4 + $urandom % 5;
        p2 = 3 + $urandom % 5;
        pre = 1 + $urandom % 2;
        tick(3);
        rstn = 1'b1;
        // load period while idle, random duty and polarity
        period_data = 16'(p);
        period_wr = 1'b1;
        duty_data = 16'($urandom % p);
        duty_wr = 1'b1;
        cfg.polarity = 1'($urandom);
        tick(1);
        period_wr = 1'b0;
        duty_wr = 1'b0;
        // center-aligned enable: event at once, long first period
        // the start event is consumed before any period event
        cfg.center_align_select = 1'b1;
        chan_enable = 1'b1;
        n = cyc;
        nw = n + p + 2;
        q.push_back(n + 1);
        q.push_back(nw);
        q.push_back(nw + p);
        q.push_back(nw + 2 * p);
        tick(1);
        chk("cnt_start", 16'h0000, cnt_value);
        chk("enabled_on", 1'b1, channel_enabled_bit);
        // zero update in the second period leaves the period alone
        tick_to(nw + 1);
        upd_wr = 1'b1;
        tick(1);
        upd_wr = 1'b0;
        // back-to-back updates, the later one stands
        tick_to(nw + p + 1);
        upd_data = 16'(p + 5);
        upd_wr = 1'b1;
        tick(1);
        upd_data = 16'(p2);
        tick(1);
        upd_wr = 1'b0;
        // disable mid-period: status holds until the wrap
        tick_to(nw + 2 * p + 1);
        chan_enable = 1'b0;
        while (cyc < nw + 2 * p + p2) begin
            chk("enabled_drain", 1'b1, channel_enabled_bit);
            tick(1);
        end
        chk("enabled_off", 1'b0, channel_enabled_bit);
        chk("cnt_off", 16'h0000, cnt_value);
        chk("idle_level", cfg.polarity, pwm_out);
        tick(1);
        chk("enabled_later", 1'b0, channel_enabled_bit);
        // left-aligned enable on a slower channel clock, updated period
        cfg.center_align_select = 1'b0;
        cfg.prescale = 4'(pre);
        chan_enable = 1'b1;
        n = cyc;
        q.push_back(n + 1 + ((p2 + 1) << pre));
        tick_to(n + 2 + ((p2 + 1) << pre));
        chk("queue_empty", 0, q.size());
        report_and_stop();
    end
endmodule : tb

`default_nettype wire
